// ===== logic/pcd_pkg.sv
/*
 * Shared constants and carrier types of the pin change detector:
 * register offsets, field positions, reset values, AXI4-Lite channel
 * structs. Assumes a 32-bit AXI4-Lite master with an 8-bit address.
 */
package pcd_pkg;

    localparam int NPIN = 16;
    localparam int NIRQ = 2;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] RISE_OFF = 8'h04;
    localparam logic [7:0] FALL_OFF = 8'h08;
    localparam logic [7:0] FLAG_OFF = 8'h0C;
    localparam logic [7:0] PU_OFF   = 8'h10;
    localparam logic [7:0] PD_OFF   = 8'h14;
    localparam logic [7:0] SUM_OFF  = 8'h18;
    localparam logic [7:0] ISTA_OFF = 8'h1C;
    localparam logic [7:0] IMSK_OFF = 8'h20;
    localparam logic [7:0] PIN_OFF  = 8'h24;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int ON_BIT       = 0;
    localparam int SUM_BIT      = 0;
    localparam int IRQ_RISE_BIT = 0;
    localparam int IRQ_FALL_BIT = 1;

    localparam logic            ON_RST   = 1'b0;
    localparam logic [15:0]     EN_RST   = 16'h0000;
    localparam logic            FLAG_RST = 1'b0;
    localparam logic [NIRQ-1:0] IRQ_RST  = 2'h0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // AXI4-Lite carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [7:0]  araddr;
        logic        arvalid;
        logic        rready;
    } axil_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } axil_rsp_t;

endpackage

// ===== logic/pin_sync.sv
/*
 * Two-flop synchroniser for a vector of asynchronous pin levels.
 * Assumes each bit is an independent level; no bus coherence.
 */
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_st_t;

    sync_st_t st_r;
    sync_st_t st_nxt;

    always_comb
    begin
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign q = st_r.s2;

endmodule

// ===== logic/edge_cell.sv
/*
 * Edge detector and sticky change flag of one pin.
 * Assumes sample is already synchronised to aclk and clear is a
 * one-cycle strobe from the register file.
 */
`timescale 1ns/1ps
module edge_cell
    import pcd_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic sample,
    input  wire logic detect_on,
    input  wire logic rise_en,
    input  wire logic fall_en,
    input  wire logic clear,
    output logic      flag,
    output logic      rise_hit,
    output logic      fall_hit
);

    typedef struct packed {
        logic prev;
        logic flag;
    } cell_st_t;

    cell_st_t st_r;
    cell_st_t st_nxt;

    always_comb
    begin
        rise_hit    = detect_on & rise_en & sample & ~st_r.prev;
        fall_hit    = detect_on & fall_en & ~sample & st_r.prev;
        // prev tracks the pin even while off, so switching on is quiet
        st_nxt.prev = sample;
        if (rise_hit || fall_hit)
            st_nxt.flag = 1'b1;
        else if (clear)
            st_nxt.flag = 1'b0;
        else
            st_nxt.flag = st_r.flag;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_r <= '{prev: 1'b0, flag: FLAG_RST};
        else
            st_r <= st_nxt;
    end

    assign flag = st_r.flag;

endmodule

// ===== logic/pin_change_detector.sv
/*
 * Pin change detector of one 16-pin port with pull controls, an
 * interrupt status/mask pair and an AXI4-Lite register slave.
 * Assumes pin_in is asynchronous and the bus master is AXI4-Lite.
 */
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps

// Function
// - a set falling enable arms falling edge detection on its pin.
// - an enabled edge sets the pin flag, the summary and the interrupt status.
// - a pin flag sets on an enabled rising or falling edge.
// - with both enables set, edges of either polarity are flagged.
// - with both enables clear, the pin is not watched at all.
// - writing zero to a pin flag clears it until the next edge.
// - software writes can never set a pin flag.
// - a pull-up enable bit switches the weak pull-up of its pin.
// - a pull-down enable bit switches the weak pull-down of its pin.
// - the read-only summary is set while any pin flag is set.
// - a set rising enable arms rising edge detection on its pin.
module pin_change_detector (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire pcd_pkg::axil_req_t  axi_req,
    output pcd_pkg::axil_rsp_t       axi_rsp,
    input  wire logic [15:0]         pin_in,
    output logic      [15:0]         pullup_en,
    output logic      [15:0]         pulldown_en,
    output logic                     irq
);
    import pcd_pkg::*;

    typedef struct packed {
        logic            on;
        logic [15:0]     rise;
        logic [15:0]     fall;
        logic [15:0]     pu;
        logic [15:0]     pd;
        logic [NIRQ-1:0] ista;
        logic [NIRQ-1:0] imsk;
        logic            aw_got;
        logic [7:0]      waddr;
        logic            w_got;
        logic [31:0]     wdata;
        logic [3:0]      wstrb;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            rvalid;
        logic [31:0]     rdata;
        logic [1:0]      rresp;
    } ctl_st_t;

    localparam ctl_st_t ST_RST = '{
        on:   ON_RST,
        rise: EN_RST,
        fall: EN_RST,
        pu:   EN_RST,
        pd:   EN_RST,
        ista: IRQ_RST,
        imsk: IRQ_RST,
        default: '0
    };

    ctl_st_t         st_r;
    ctl_st_t         st_nxt;
    logic [15:0]     pin_s;
    logic [15:0]     flags;
    logic [15:0]     rise_hit;
    logic [15:0]     fall_hit;
    logic [15:0]     clr;
    logic [15:0]     lane;
    logic [NIRQ-1:0] w1c;
    logic [NIRQ-1:0] evt;
    logic [31:0]     rd_word;
    logic [1:0]      rd_resp;
    logic [7:0]      raddr;
    logic            summary;
    logic            wr_fire;
    logic            awready;
    logic            wready;
    logic            arready;

    // ------------------------------------------------------------
    // pin sampling and per-pin detectors
    // ------------------------------------------------------------
    pin_sync #(
        .W (NPIN)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (pin_in),
        .q       (pin_s)
    );

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++)
        begin : g_pin
            edge_cell u_cell (
                .aclk      (aclk),
                .aresetn   (aresetn),
                .sample    (pin_s[gi]),
                .detect_on (st_r.on),
                .rise_en   (st_r.rise[gi]),
                .fall_en   (st_r.fall[gi]),
                .clear     (clr[gi]),
                .flag      (flags[gi]),
                .rise_hit  (rise_hit[gi]),
                .fall_hit  (fall_hit[gi])
            );
        end
    endgenerate

    assign summary = |flags;

    // ------------------------------------------------------------
    // bus handshakes and outputs
    // ------------------------------------------------------------
    assign awready = ~st_r.aw_got & ~st_r.bvalid;
    assign wready  = ~st_r.w_got & ~st_r.bvalid;
    assign arready = ~st_r.rvalid;
    assign wr_fire = st_r.aw_got & st_r.w_got & ~st_r.bvalid;
    assign lane    = {{8{st_r.wstrb[1]}}, {8{st_r.wstrb[0]}}};
    assign raddr   = {axi_req.araddr[7:2], 2'b00};
    assign evt     = {|fall_hit, |rise_hit};

    assign axi_rsp.awready = awready;
    assign axi_rsp.wready  = wready;
    assign axi_rsp.bvalid  = st_r.bvalid;
    assign axi_rsp.bresp   = st_r.bresp;
    assign axi_rsp.arready = arready;
    assign axi_rsp.rvalid  = st_r.rvalid;
    assign axi_rsp.rdata   = st_r.rdata;
    assign axi_rsp.rresp   = st_r.rresp;

    assign pullup_en   = st_r.pu;
    assign pulldown_en = st_r.pd;
    assign irq         = |(st_r.ista & st_r.imsk);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_nxt  = st_r;
        clr     = '0;
        w1c     = '0;
        rd_word = '0;
        rd_resp = RESP_OKAY;
        if (axi_req.awvalid && awready)
        begin
            st_nxt.aw_got = 1'b1;
            st_nxt.waddr  = {axi_req.awaddr[7:2], 2'b00};
        end
        if (axi_req.wvalid && wready)
        begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = axi_req.wdata;
            st_nxt.wstrb = axi_req.wstrb;
        end
        if (st_r.bvalid && axi_req.bready)
            st_nxt.bvalid = 1'b0;
        if (wr_fire)
        begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = RESP_OKAY;
            if (st_r.waddr == CTRL_OFF)
            begin
                if (st_r.wstrb[0])
                    st_nxt.on = st_r.wdata[ON_BIT];
            end
            else if (st_r.waddr == RISE_OFF)
                st_nxt.rise = (st_r.rise & ~lane)
                            | (st_r.wdata[15:0] & lane);
            else if (st_r.waddr == FALL_OFF)
                st_nxt.fall = (st_r.fall & ~lane)
                            | (st_r.wdata[15:0] & lane);
            else if (st_r.waddr == FLAG_OFF)
                // zeros clear, ones leave the flag alone
                clr = lane & ~st_r.wdata[15:0];
            else if (st_r.waddr == PU_OFF)
                st_nxt.pu = (st_r.pu & ~lane)
                          | (st_r.wdata[15:0] & lane);
            else if (st_r.waddr == PD_OFF)
                st_nxt.pd = (st_r.pd & ~lane)
                          | (st_r.wdata[15:0] & lane);
            else if (st_r.waddr == ISTA_OFF)
                w1c = lane[NIRQ-1:0] & st_r.wdata[NIRQ-1:0];
            else if (st_r.waddr == IMSK_OFF)
                st_nxt.imsk = (st_r.imsk & ~lane[NIRQ-1:0])
                            | (st_r.wdata[NIRQ-1:0] & lane[NIRQ-1:0]);
            else if (st_r.waddr == SUM_OFF || st_r.waddr == PIN_OFF)
                st_nxt.bresp = RESP_OKAY;
            else
                st_nxt.bresp = RESP_SLVERR;
        end
        // a new event in the clearing cycle survives
        st_nxt.ista = (st_r.ista & ~w1c) | evt;

        if (raddr == CTRL_OFF)
            rd_word[ON_BIT] = st_r.on;
        else if (raddr == RISE_OFF)
            rd_word[15:0] = st_r.rise;
        else if (raddr == FALL_OFF)
            rd_word[15:0] = st_r.fall;
        else if (raddr == FLAG_OFF)
            rd_word[15:0] = flags;
        else if (raddr == PU_OFF)
            rd_word[15:0] = st_r.pu;
        else if (raddr == PD_OFF)
            rd_word[15:0] = st_r.pd;
        else if (raddr == SUM_OFF)
            rd_word[SUM_BIT] = summary;
        else if (raddr == ISTA_OFF)
            rd_word[NIRQ-1:0] = st_r.ista;
        else if (raddr == IMSK_OFF)
            rd_word[NIRQ-1:0] = st_r.imsk;
        else if (raddr == PIN_OFF)
            rd_word[15:0] = pin_s;
        else
            rd_resp = RESP_SLVERR;

        if (st_r.rvalid && axi_req.rready)
            st_nxt.rvalid = 1'b0;
        if (axi_req.arvalid && arready)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = rd_word;
            st_nxt.rresp  = rd_resp;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_r <= ST_RST;
        else
            st_r <= st_nxt;
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    fall_gate_a: assert property (
        (fall_hit & ~st_r.fall) == 16'h0000)
        else $error("falling edge flagged while disarmed");

    flag_set_a: assert property (
        |(rise_hit | fall_hit) |=>
        (flags & $past(rise_hit | fall_hit)) == $past(rise_hit | fall_hit))
        else $error("detected edge did not set its flag");

    irq_follow_a: assert property (
        |(rise_hit | fall_hit) |=> ##[0:1] (summary && st_r.ista != 2'h0))
        else $error("edge did not reach summary and status");

    both_edge_a: assert property (
        st_r.on |-> ((rise_hit | fall_hit) & st_r.rise & st_r.fall)
        == ((pin_s ^ $past(pin_s)) & st_r.rise & st_r.fall))
        else $error("both-edge pin missed an edge");

    no_watch_a: assert property (
        ((rise_hit | fall_hit) & ~(st_r.rise | st_r.fall)) == 16'h0000)
        else $error("unwatched pin produced an edge");

    flag_clear_a: assert property (
        |(clr & ~rise_hit & ~fall_hit) |=>
        (flags & $past(clr & ~rise_hit & ~fall_hit)) == 16'h0000)
        else $error("written zero did not clear the flag");

    sw_noset_a: assert property (
        (flags & ~$past(flags) & ~$past(rise_hit | fall_hit)) == 16'h0000)
        else $error("flag set without a detected edge");

    pull_up_a: assert property (
        wr_fire && st_r.waddr == PU_OFF && st_r.wstrb[1:0] == 2'h3
        |=> pullup_en == $past(st_r.wdata[15:0]))
        else $error("pull-up enable not taken from write");

    pull_down_a: assert property (
        wr_fire && st_r.waddr == PD_OFF && st_r.wstrb[1:0] == 2'h3
        |=> pulldown_en == $past(st_r.wdata[15:0]))
        else $error("pull-down enable not taken from write");

    sum_fall_a: assert property (
        $fell(summary) |-> $past(|clr) && flags == 16'h0000)
        else $error("summary cleared without flag clear");

    rise_gate_a: assert property (
        (rise_hit & ~st_r.rise) == 16'h0000)
        else $error("rising edge flagged while disarmed");

    off_quiet_a: assert property (
        !st_r.on |-> (rise_hit | fall_hit) == 16'h0000)
        else $error("edge detected while module off");

    reset_zero_a: assert property (
        $rose(aresetn) |-> flags == 16'h0000 && pullup_en == 16'h0000
        && pulldown_en == 16'h0000 && !st_r.on)
        else $error("state not cleared by reset");

    flag_hold_a: assert property (
        (~flags & $past(flags) & ~$past(clr)) == 16'h0000)
        else $error("flag dropped without a software clear");

    ista_set_a: assert property (
        evt != 2'h0 |=> (st_r.ista & $past(evt)) == $past(evt))
        else $error("edge event did not set interrupt status");

    flag_read_a: assert property (
        axi_req.arvalid && arready && raddr == FLAG_OFF
        |=> st_r.rdata[15:0] == $past(flags))
        else $error("flag read returned wrong value");

    sum_read_a: assert property (
        axi_req.arvalid && arready && raddr == SUM_OFF
        |=> st_r.rdata[SUM_BIT] == $past(|flags))
        else $error("summary read returned wrong value");

    ctrl_write_a: assert property (
        wr_fire && st_r.waddr == CTRL_OFF && st_r.wstrb[0]
        |=> st_r.on == $past(st_r.wdata[ON_BIT]))
        else $error("detection enable not taken from write");

    write_resp_a: assert property (
        wr_fire |=> st_r.bvalid && !awready && !wready)
        else $error("write response missing after both halves");

    read_resp_a: assert property (
        axi_req.arvalid && arready |=> st_r.rvalid && !arready)
        else $error("read response missing after address taken");

    cov_write_c: cover property (wr_fire ##1 st_r.bvalid);
    cov_read_c: cover property (st_r.rvalid && axi_req.rready);
    cov_irq_c: cover property ($rose(irq));
    cov_both_c: cover property (|(rise_hit & st_r.fall) ##[1:50]
                                |(fall_hit & st_r.rise));

endmodule

// ===== tb/pin_model.sv
/*
 * Behavioural model of the sixteen external pins of one port.
 * Assumes the bench sets drive levels and enables; a released pin
 * follows its weak pull, or toggles every cycle when none is on.
 */
`timescale 1ns/1ps
module pin_model (
    input  wire logic        aclk,
    input  wire logic [15:0] drv_val,
    input  wire logic [15:0] drv_oe,
    input  wire logic [15:0] pullup_en,
    input  wire logic [15:0] pulldown_en,
    output logic      [15:0] pin_lvl
);
    logic [15:0] float_r = 16'h0000;

    // an undriven, unpulled pin shows no stable level
    always @(posedge aclk)
        float_r <= ~float_r;

    always_comb
        pin_lvl = (drv_oe & drv_val)
                | (~drv_oe & pullup_en)
                | (~drv_oe & ~pullup_en & ~pulldown_en & float_r);
endmodule

// ===== tb/pin_change_detector_tb.sv
/*
 * Self-checking bench of the pin change detector: AXI4-Lite master
 * tasks, expected results queued and compared by a bus monitor.
 * Assumes the pcd_pkg register map and tb/pin_model.sv.
 */
`timescale 1ns/1ps
module pin_change_detector_tb;
    import pcd_pkg::*;
    logic        aclk;
    logic        aresetn;
    axil_req_t   req;
    axil_rsp_t   rsp;
    logic [15:0] pin_lvl;
    logic [15:0] pu;
    logic [15:0] pd;
    logic        irq;
    logic [15:0] dv;
    logic [15:0] doe;
    logic [33:0] exq[$];
    logic [31:0] lf;
    logic [15:0] ra;
    logic [15:0] fa;
    int          fails;
    int          tests_run;

    pin_change_detector pin_change_detector_inst (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .axi_req     (req),
        .axi_rsp     (rsp),
        .pin_in      (pin_lvl),
        .pullup_en   (pu),
        .pulldown_en (pd),
        .irq         (irq)
    );

    pin_model pin_model_inst (
        .aclk        (aclk),
        .drv_val     (dv),
        .drv_oe      (doe),
        .pullup_en   (pu),
        .pulldown_en (pd),
        .pin_lvl     (pin_lvl)
    );

    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic chk(input string nm, input logic [33:0] seen,
                       input logic [33:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic results;
        $display("fails %0d tests_run %0d", fails, tests_run);
        if (fails == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge aclk);
    endtask

    // bready and rready stay high, so every answer is taken at once
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] r);
        int n;
        exq.push_back({r, 32'h0});
        req.awaddr  <= a;
        req.wdata   <= d;
        req.wstrb   <= s;
        req.awvalid <= 1'b1;
        req.wvalid  <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            if (req.awvalid && rsp.awready)
                req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready)
                req.wvalid <= 1'b0;
            n++;
            if (n > 50)
            begin
                fails++;
                results();
            end
        end
        while (rsp.bvalid !== 1'b1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        int n;
        exq.push_back({r, d});
        req.araddr  <= a;
        req.arvalid <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            if (req.arvalid && rsp.arready)
                req.arvalid <= 1'b0;
            n++;
            if (n > 50)
            begin
                fails++;
                results();
            end
        end
        while (rsp.rvalid !== 1'b1);
    endtask

    always @(posedge aclk)
    begin
        if (aresetn && rsp.bvalid === 1'b1)
            chk("bresp", {rsp.bresp, 32'h0}, exq.pop_front());
        if (aresetn && rsp.rvalid === 1'b1)
            chk("rdata", {rsp.rresp, rsp.rdata}, exq.pop_front());
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        req = '0;
        req.bready = 1'b1;
        req.rready = 1'b1;
        aresetn = 1'b0;
        dv = 16'h0000;
        doe = 16'hFFFF;
        lf = 32'h0001686F; // seed 92271
        fails = 0;
        tests_run = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("pulls", {2'h0, pu, pd}, 34'h0);
        chk("irq", {33'h0, irq}, 34'h0);
        for (int i = 0; i < 10; i++)
            rd(8'(4 * i), 32'h0, RESP_OKAY);
        rd(8'h28, 32'h0, RESP_SLVERR);
        wr(8'h28, 32'h0000FFFF, 4'hF, RESP_SLVERR);
        lf = nxt(lf);
        wr(PU_OFF, {16'h0, lf[15:0]}, 4'hF, RESP_OKAY);
        wr(PD_OFF, {16'h0, ~lf[15:0]}, 4'hF, RESP_OKAY);
        doe <= 16'h0000;
        tick(4);
        chk("pullup_en", {18'h0, pu}, {18'h0, lf[15:0]});
        chk("pulldown_en", {18'h0, pd}, {18'h0, ~lf[15:0]});
        rd(PIN_OFF, {16'h0, lf[15:0]}, RESP_OKAY);
        wr(PU_OFF, 32'h0, 4'h2, RESP_OKAY);
        chk("pullup lane", {18'h0, pu}, {26'h0, lf[7:0]});
        wr(PD_OFF, 32'h0, 4'hF, RESP_OKAY);
        chk("pulldown off", {18'h0, pd}, 34'h0);
        doe <= 16'hFFFF;
        tick(4);
        // pin 0 watches both edges, pin 1 none
        lf = nxt(lf);
        ra = (lf[15:0] | 16'h0001) & 16'hFFFD;
        lf = nxt(lf);
        fa = (lf[15:0] | 16'h0001) & 16'hFFFD;
        wr(CTRL_OFF, 32'h1, 4'hF, RESP_OKAY);
        wr(RISE_OFF, {16'h0, ra}, 4'hF, RESP_OKAY);
        wr(FALL_OFF, {16'h0, fa}, 4'hF, RESP_OKAY);
        wr(FLAG_OFF, 32'h0, 4'hF, RESP_OKAY);
        wr(ISTA_OFF, 32'h3, 4'hF, RESP_OKAY);
        dv <= 16'hFFFF;
        tick(5);
        rd(FLAG_OFF, {16'h0, ra}, RESP_OKAY);
        rd(SUM_OFF, 32'h1, RESP_OKAY);
        rd(ISTA_OFF, 32'h1, RESP_OKAY);
        wr(FLAG_OFF, 32'h0, 4'hF, RESP_OKAY);
        rd(FLAG_OFF, 32'h0, RESP_OKAY);
        rd(SUM_OFF, 32'h0, RESP_OKAY);
        dv <= 16'h0000;
        tick(5);
        rd(FLAG_OFF, {16'h0, fa}, RESP_OKAY);
        rd(ISTA_OFF, 32'h3, RESP_OKAY);
        wr(FLAG_OFF, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
        rd(FLAG_OFF, {16'h0, fa}, RESP_OKAY);
        wr(FLAG_OFF, 32'h0, 4'h1, RESP_OKAY);
        rd(FLAG_OFF, {16'h0, fa & 16'hFF00}, RESP_OKAY);
        chk("irq masked", {33'h0, irq}, 34'h0);
        wr(IMSK_OFF, 32'h2, 4'hF, RESP_OKAY);
        chk("irq unmasked", {33'h0, irq}, 34'h1);
        wr(ISTA_OFF, 32'h2, 4'hF, RESP_OKAY);
        chk("irq cleared", {33'h0, irq}, 34'h0);
        rd(ISTA_OFF, 32'h1, RESP_OKAY);
        wr(CTRL_OFF, 32'h0, 4'hF, RESP_OKAY);
        wr(FLAG_OFF, 32'h0, 4'hF, RESP_OKAY);
        lf = nxt(lf);
        dv <= lf[15:0];
        tick(5);
        rd(FLAG_OFF, 32'h0, RESP_OKAY);
        wr(CTRL_OFF, 32'h1, 4'hF, RESP_OKAY);
        tick(5);
        rd(FLAG_OFF, 32'h0, RESP_OKAY);
        results();
    end
endmodule
